// *** shared/apc_cfg.svh ***
// Purpose: Offsets, field positions, reset values and counts of the converter control block
// Assumes: Register index times four is the APB byte address
// Notes:   Definitions only
`ifndef APC_CFG_SVH
`define APC_CFG_SVH

// ==========================================================================
// Register indices (byte address = index * 4)
`define APC_IDX_RSV_A       3'h0
`define APC_IDX_RSV_B       3'h1
`define APC_IDX_CTRL        3'h2
`define APC_IDX_IRQ_STATUS  3'h3
`define APC_IDX_IRQ_MASK    3'h4
`define APC_IDX_CCF_STATUS  3'h5
`define APC_IDX_LAST        3'h5

// ==========================================================================
// Control register fields
`define APC_BIT_POWER_UP    7
`define APC_BIT_FAST_CLEAR  6
`define APC_BIT_WAIT_PD     5
`define APC_BIT_TRIG_LEVEL  4
`define APC_BIT_TRIG_POL    3
`define APC_BIT_TRIG_EN     2
`define APC_BIT_SEQ_IE      1
`define APC_BIT_SEQ_IF      0

// ==========================================================================
// Interrupt status fields
`define APC_IRQ_SEQ_DONE    0
`define APC_IRQ_TRIGGER     1
`define APC_IRQ_ABORT       2
`define APC_IRQ_WIDTH       3

// ==========================================================================
// Reset values
`define APC_RST_BYTE        8'h00
`define APC_RST_CTRL        8'h00
`define APC_RST_IRQ         3'h0
`define APC_RST_WORD        32'h0000_0000

// ==========================================================================
// Sizes
`define APC_CHANNELS        8

`endif

// *** shared/apc_pkg.sv ***
// Purpose: Types shared by the converter control block
// Assumes: apc_cfg.svh holds the numbers
// Notes:   Types only
package apc_pkg;

   // One control byte
   typedef logic [7:0] apc_byte_t;

   // One flag per analog channel
   typedef logic [7:0] apc_chan_t;

   // APB word
   typedef logic [31:0] apc_word_t;

   // External trigger sensitivity, coded as {level_sel, polarity}
   typedef enum logic [1:0]
   {
      APC_TRIG_FALL,
      APC_TRIG_RISE,
      APC_TRIG_LOW,
      APC_TRIG_HIGH
   } apc_trig_e;

endpackage : apc_pkg

// *** rtl/apc_trigger_detect.sv ***
// Purpose: External trigger detector on the channel 7 pin
// Assumes: trig_level is already synchronised to pclk
// Notes:   Output pulses for edges, stays high for an active level
`timescale 1ns/100ps
`default_nettype none

module apc_trigger_detect
   import apc_pkg::*;
(
   // Clock and reset
   input  wire logic           pclk,
   input  wire logic           presetn,
   // Configuration
   input  wire logic           enable,
   input  wire logic           power_up_bit,
   input  wire apc_pkg::apc_trig_e mode,
   // Trigger input and result
   input  wire logic           trig_level,
   output logic                trig_start
);

   // ========================================================================
   // Edge detection
   logic prev_level;
   logic hit;
   logic armed;

   // Detector only listens while enabled and powered
   assign armed = enable & power_up_bit;

   // Sensitivity decode
   always_comb
   begin
      case (mode)
         APC_TRIG_FALL: hit = prev_level & ~trig_level;
         APC_TRIG_RISE: hit = ~prev_level & trig_level;
         APC_TRIG_LOW:  hit = ~trig_level;
         APC_TRIG_HIGH: hit = trig_level;
         default:       hit = 1'b0;
      endcase
   end

   // Previous level and registered trigger
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_level <= 1'b0;
         trig_start <= 1'b0;
      end
      else
      begin
         prev_level <= trig_level;
         trig_start <= hit & armed;
      end
   end

endmodule : apc_trigger_detect

`default_nettype wire

// *** rtl/apc_ccf_flags.sv ***
// Purpose: Per-channel conversion complete flags with normal and fast clearing
// Assumes: All strobes are one-cycle pulses on pclk
// Notes:   A set in the same cycle as a clear wins
`timescale 1ns/100ps
`default_nettype none
`include "apc_cfg.svh"

module apc_ccf_flags
   import apc_pkg::*;
(
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // Mode
   input  wire logic              fast_flag_clear,
   // Events
   input  wire apc_pkg::apc_chan_t ccf_set,
   input  wire logic              status_read,
   input  wire apc_pkg::apc_chan_t result_access,
   input  wire apc_pkg::apc_chan_t result_read,
   // Flags
   output apc_pkg::apc_chan_t     conversion_complete_flag
);

   // ========================================================================
   // Per-channel flag and clear arming
   genvar ch;
   generate
      for (ch = 0; ch < `APC_CHANNELS; ch = ch + 1)
      begin : g_chan
         logic armed;
         logic clr;

         // Normal: status read then result read; fast: any result access
         assign clr = fast_flag_clear ? result_access[ch]
                                      : (armed & result_read[ch]);

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               conversion_complete_flag[ch] <= 1'b0;
               armed                        <= 1'b0;
            end
            else
            begin
               if (ccf_set[ch])
                  conversion_complete_flag[ch] <= 1'b1;
               else if (clr)
                  conversion_complete_flag[ch] <= 1'b0;
               // Status read arms only a flag that is visibly set
               if (ccf_set[ch] | clr)
                  armed <= 1'b0;
               else if (status_read & conversion_complete_flag[ch])
                  armed <= 1'b1;
            end
         end
      end
   endgenerate

endmodule : apc_ccf_flags

`default_nettype wire

// *** rtl/apc_control.sv ***
// Purpose: Power, trigger and interrupt control of an 8-channel converter, APB slave
// Assumes: Converter core and result registers sit outside, on pclk
// Notes:   One wait state on every APB access; all outputs registered
//
// Summary of operation
// - Normal mode: reserved registers A and B read zero, writes ignored.
// - Special mode: reserved registers A and B are writable and drive the core.
// - Control register write aborts the running sequence, starts nothing.
// - Bit 7 clear powers the converter down; set gives normal operation.
// - Fast clear off: flag clears on status read followed by result read.
// - Fast clear on: any result register access clears that channel flag.
// - Bit 5 set halts and powers down the converter during wait mode.
// - Conversion resumes after wait; software discards that first result.
// - Bits 4 and 3 select falling, rising, low or high trigger sensitivity.
// - Bit 2 enables channel 7 as external trigger input.
// - Bit 1 enables the sequence complete interrupt request.
// - Bit 0 reads sequence complete flag when enabled, else zero.
// - Writes to bit 0 are ignored.
// - Control write, or reserved write in special mode, resets the result slot counter.
`timescale 1ns/100ps
`default_nettype none
`include "apc_cfg.svh"

module apc_control
   import apc_pkg::*;
(
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire apc_pkg::apc_word_t pwdata,
   output apc_pkg::apc_word_t      prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Pins
   input  wire logic               special_mode_pin,
   input  wire logic               trigger_pin,
   // System state (pclk domain)
   input  wire logic               wait_mode,
   // Converter core status (pclk domain)
   input  wire logic               sequence_complete_flag,
   input  wire apc_pkg::apc_chan_t ccf_set,
   input  wire apc_pkg::apc_chan_t result_access,
   input  wire apc_pkg::apc_chan_t result_read,
   // Converter core control
   output logic                    converter_power,
   output logic                    conversion_halt,
   output logic                    sequence_abort,
   output logic                    slot_counter_reset,
   output logic                    trigger_start,
   output apc_pkg::apc_byte_t      test_control_a,
   output apc_pkg::apc_byte_t      test_control_b,
   output apc_pkg::apc_chan_t      conversion_complete_flag,
   // Interrupts
   output logic                    sequence_irq,
   output logic                    irq
);

   // ========================================================================
   // Pin synchronisers: first stage read only by the second
   logic special_meta;
   logic special_mode;
   logic trig_meta;
   logic trig_sync;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         special_meta <= 1'b0;
         special_mode <= 1'b0;
         trig_meta    <= 1'b0;
         trig_sync    <= 1'b0;
      end
      else
      begin
         special_meta <= special_mode_pin;
         special_mode <= special_meta;
         trig_meta    <= trigger_pin;
         trig_sync    <= trig_meta;
      end
   end

   // ========================================================================
   // APB decode
   logic       setup_done;
   logic       acc;
   logic       wr;
   logic       rd;
   logic [2:0] idx;
   logic       aligned;
   logic       mapped;

   // Access completes at the edge where pready is high
   assign setup_done = psel & penable & ~pready;
   assign acc        = psel & penable & pready;
   assign wr         = acc & pwrite & mapped;
   assign rd         = acc & ~pwrite & mapped;
   assign idx        = paddr[4:2];
   assign aligned    = (paddr[1:0] == 2'b00) & (paddr[7:5] == 3'b000);
   assign mapped     = aligned & (idx <= `APC_IDX_LAST);

   // Per-register write strobes, plus the CCF status read strobe
   logic wr_rsv_a;
   logic wr_rsv_b;
   logic wr_ctrl;
   logic wr_irq_status;
   logic wr_irq_mask;
   logic rd_ccf_status;

   // Reserved locations take writes only in special mode
   assign wr_rsv_a      = wr & (idx == `APC_IDX_RSV_A) & special_mode;
   assign wr_rsv_b      = wr & (idx == `APC_IDX_RSV_B) & special_mode;
   assign wr_ctrl       = wr & (idx == `APC_IDX_CTRL);
   assign wr_irq_status = wr & (idx == `APC_IDX_IRQ_STATUS);
   assign wr_irq_mask   = wr & (idx == `APC_IDX_IRQ_MASK);
   assign rd_ccf_status = rd & (idx == `APC_IDX_CCF_STATUS);

   // ========================================================================
   // Control and reserved registers
   apc_byte_t ctrl;
   apc_byte_t rsv_a;
   apc_byte_t rsv_b;
   apc_byte_t next_ctrl;

   // Bit 0 is not storage; keep it zero so writes never land
   assign next_ctrl = {pwdata[7:1], 1'b0};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl  <= `APC_RST_CTRL;
         rsv_a <= `APC_RST_BYTE;
         rsv_b <= `APC_RST_BYTE;
      end
      else
      begin
         if (wr_ctrl)
            ctrl <= next_ctrl;
         if (wr_rsv_a)
            rsv_a <= pwdata[7:0];
         if (wr_rsv_b)
            rsv_b <= pwdata[7:0];
      end
   end

   // Named control fields
   logic      power_up_bit;
   logic      fast_flag_clear;
   logic      wait_power_down;
   logic      external_trigger_enable;
   logic      sequence_irq_enable;
   logic      sequence_irq_flag;
   apc_trig_e trig_mode;

   assign power_up_bit            = ctrl[`APC_BIT_POWER_UP];
   assign fast_flag_clear         = ctrl[`APC_BIT_FAST_CLEAR];
   assign wait_power_down         = ctrl[`APC_BIT_WAIT_PD];
   assign external_trigger_enable = ctrl[`APC_BIT_TRIG_EN];
   assign sequence_irq_enable     = ctrl[`APC_BIT_SEQ_IE];
   assign trig_mode               = apc_trig_e'({ctrl[`APC_BIT_TRIG_LEVEL],
                                                 ctrl[`APC_BIT_TRIG_POL]});
   // Flag mirrors the core status only while enabled
   assign sequence_irq_flag = sequence_irq_enable & sequence_complete_flag;

   // ========================================================================
   // Converter core control, all registered
   logic any_ctrl_write;

   // Reserved writes count only where they take effect
   assign any_ctrl_write = wr_ctrl | wr_rsv_a | wr_rsv_b;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         converter_power    <= 1'b0;
         conversion_halt    <= 1'b0;
         sequence_abort     <= 1'b0;
         slot_counter_reset <= 1'b0;
         test_control_a     <= `APC_RST_BYTE;
         test_control_b     <= `APC_RST_BYTE;
         sequence_irq       <= 1'b0;
      end
      else
      begin
         // Powered only when enabled and not parked in wait mode
         converter_power    <= power_up_bit & ~(wait_mode & wait_power_down);
         // Halt lifts as wait ends, so the core resumes the same conversion
         conversion_halt    <= ~power_up_bit | (wait_mode & wait_power_down);
         sequence_abort     <= wr_ctrl;
         slot_counter_reset <= any_ctrl_write;
         // Special mode lost: the core sees inert test bytes again
         test_control_a     <= special_mode ? rsv_a : `APC_RST_BYTE;
         test_control_b     <= special_mode ? rsv_b : `APC_RST_BYTE;
         // One register stage keeps the output glitch free
         sequence_irq       <= sequence_irq_enable & sequence_complete_flag;
      end
   end

   // ========================================================================
   // External trigger detector
   apc_trigger_detect u_trigger
   (
      .pclk         (pclk),
      .presetn      (presetn),
      .enable       (external_trigger_enable),
      .power_up_bit (power_up_bit),
      .mode         (trig_mode),
      .trig_level   (trig_sync),
      .trig_start   (trigger_start)
   );

   // ========================================================================
   // Conversion complete flags
   apc_ccf_flags u_flags
   (
      .pclk                     (pclk),
      .presetn                  (presetn),
      .fast_flag_clear          (fast_flag_clear),
      .ccf_set                  (ccf_set),
      .status_read              (rd_ccf_status),
      .result_access            (result_access),
      .result_read              (result_read),
      .conversion_complete_flag (conversion_complete_flag)
   );

   // ========================================================================
   // Block interrupt: sticky status, mask, write one to clear
   logic [`APC_IRQ_WIDTH-1:0] irq_status;
   logic [`APC_IRQ_WIDTH-1:0] irq_mask;
   logic [`APC_IRQ_WIDTH-1:0] irq_event;
   logic [`APC_IRQ_WIDTH-1:0] next_irq_status;
   logic                      seq_prev;

   assign irq_event[`APC_IRQ_SEQ_DONE] = sequence_complete_flag & ~seq_prev;
   assign irq_event[`APC_IRQ_TRIGGER]  = trigger_start;
   assign irq_event[`APC_IRQ_ABORT]    = sequence_abort;
   // A new event beats a clear in the same cycle
   assign next_irq_status = (irq_status & ~({`APC_IRQ_WIDTH{wr_irq_status}}
                            & pwdata[`APC_IRQ_WIDTH-1:0])) | irq_event;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         seq_prev   <= 1'b0;
         irq_status <= `APC_RST_IRQ;
         irq_mask   <= `APC_RST_IRQ;
         irq        <= 1'b0;
      end
      else
      begin
         seq_prev   <= sequence_complete_flag;
         irq_status <= next_irq_status;
         if (wr_irq_mask)
            irq_mask <= pwdata[`APC_IRQ_WIDTH-1:0];
         irq        <= |(next_irq_status & irq_mask);
      end
   end

   // ========================================================================
   // Read mux
   apc_word_t read_word;

   always_comb
   begin
      read_word = `APC_RST_WORD;
      case (idx)
         // Reserved locations read zero outside special mode
         `APC_IDX_RSV_A:      read_word[7:0] = special_mode ? rsv_a : `APC_RST_BYTE;
         `APC_IDX_RSV_B:      read_word[7:0] = special_mode ? rsv_b : `APC_RST_BYTE;
         `APC_IDX_CTRL:       read_word[7:0] = {ctrl[7:1], sequence_irq_flag};
         `APC_IDX_IRQ_STATUS: read_word[`APC_IRQ_WIDTH-1:0] = irq_status;
         `APC_IDX_IRQ_MASK:   read_word[`APC_IRQ_WIDTH-1:0] = irq_mask;
         `APC_IDX_CCF_STATUS: read_word[7:0] = conversion_complete_flag;
         default:             read_word = `APC_RST_WORD;
      endcase
   end

   // ========================================================================
   // APB answer: one wait state, data and error captured with pready
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `APC_RST_WORD;
      end
      else
      begin
         pready  <= setup_done;
         pslverr <= setup_done & ~mapped;
         if (setup_done & ~pwrite)
            prdata <= mapped ? read_word : `APC_RST_WORD;
      end
   end

endmodule : apc_control

`default_nettype wire

// *** tb/apc_control_sva.sv ***
// Purpose: Port-level checks of the converter control block
// Assumes: One pclk domain, presetn asynchronous and active low
// Notes:   Bound to apc_control at the foot of this file
`timescale 1ns/100ps
`default_nettype none

module apc_control_sva
   import apc_pkg::*;
(
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire apc_pkg::apc_word_t pwdata,
   input  wire logic               pready,
   // Pins and core side
   input  wire logic               special_mode_pin,
   input  wire logic               wait_mode,
   input  wire logic               sequence_complete_flag,
   input  wire logic               converter_power,
   input  wire logic               conversion_halt,
   input  wire logic               sequence_abort,
   input  wire logic               slot_counter_reset,
   input  wire logic               trigger_start,
   input  wire apc_pkg::apc_byte_t test_control_a,
   input  wire apc_pkg::apc_byte_t test_control_b,
   input  wire logic               sequence_irq
);
   // ==========================================================
   // Completed write to the control register
   wire ctrl_wr = psel & penable & pready & pwrite & (paddr == 8'h08);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ==========================================================
   // Abort and counter reset follow each control write
   chk_abort_on_write: assert property (ctrl_wr |=> sequence_abort)
      else $error("no abort after control write");
   chk_abort_cause: assert property (sequence_abort |-> $past(ctrl_wr))
      else $error("abort without control write");
   chk_abort_single: assert property (sequence_abort |=> !sequence_abort)
      else $error("abort longer than one cycle");
   chk_slot_reset: assert property (ctrl_wr |=> slot_counter_reset)
      else $error("slot counter not reset on control write");

   // ==========================================================
   // Power and halt are complements once the first edge has passed
   chk_power_off: assert property (ctrl_wr && !pwdata[7] |-> ##[1:2] !converter_power)
      else $error("converter still powered after bit 7 cleared");
   chk_halt_pair: assert property (
      $past(presetn) |-> conversion_halt != converter_power)
      else $error("halt and power disagree");
   chk_trig_power: assert property (
      $rose(trigger_start) && !wait_mode |-> ##[0:1] converter_power)
      else $error("trigger while powered down");

   // ==========================================================
   // Request and reserved outputs
   chk_seq_irq_cause: assert property (
      !$past(sequence_complete_flag) |-> !sequence_irq)
      else $error("sequence request without complete status");
   chk_rsv_inert: assert property (
      !special_mode_pin [*4] |-> (test_control_a == 8'h00) && (test_control_b == 8'h00))
      else $error("reserved outputs active in normal mode");

   // Main scenarios reached
   cover property (ctrl_wr);
   cover property ($rose(trigger_start));
   cover property ($rose(sequence_irq));
endmodule : apc_control_sva

bind apc_control apc_control_sva i_apc_control_sva (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .special_mode_pin(special_mode_pin), .wait_mode(wait_mode),
   .sequence_complete_flag(sequence_complete_flag), .converter_power(converter_power),
   .conversion_halt(conversion_halt), .sequence_abort(sequence_abort),
   .slot_counter_reset(slot_counter_reset), .trigger_start(trigger_start),
   .test_control_a(test_control_a), .test_control_b(test_control_b),
   .sequence_irq(sequence_irq));

`default_nettype wire

// *** tb/adc_power_trigger_irq_control_tb_top.sv ***
// Purpose: Self-checking bench of the converter control block
// Assumes: Single APB master, an idle cycle after each transfer
// Notes:   Pins pass two synchronisers, hence the short waits after pin changes
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin error_cnt++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (x)); end end

module adc_power_trigger_irq_control_tb_top;
   import apc_pkg::*;

   // ==========================================================
   // Signals
   logic      pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic      special_mode_pin, trigger_pin, wait_mode, sequence_complete_flag;
   logic      converter_power, conversion_halt, sequence_abort, slot_counter_reset;
   logic      trigger_start, sequence_irq, irq, e;
   logic [7:0] paddr;
   apc_word_t pwdata, prdata, q;
   apc_chan_t ccf_set, result_access, result_read, conversion_complete_flag;
   apc_byte_t test_control_a, test_control_b;
   int        error_cnt, n_checks, cnt;
   // Trigger configs: fall, rise, low, high, rise unarmed, rise unpowered
   apc_byte_t tcfg [6] = '{8'h84, 8'h8C, 8'h94, 8'h9C, 8'h88, 8'h0C};

   apc_control i_apc_control (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .special_mode_pin(special_mode_pin), .trigger_pin(trigger_pin),
      .wait_mode(wait_mode), .sequence_complete_flag(sequence_complete_flag),
      .ccf_set(ccf_set), .result_access(result_access), .result_read(result_read),
      .converter_power(converter_power), .conversion_halt(conversion_halt),
      .sequence_abort(sequence_abort), .slot_counter_reset(slot_counter_reset),
      .trigger_start(trigger_start), .test_control_a(test_control_a),
      .test_control_b(test_control_b),
      .conversion_complete_flag(conversion_complete_flag),
      .sequence_irq(sequence_irq), .irq(irq));

   // Clock, 8 ns period
   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // ==========================================================
   // Tasks
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
      begin
         $display("verification passed");
      end
      else
      begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict

   // One APB transfer; the bounded wait is the only hang guard
   task automatic xfer(input logic w, input logic [7:0] a, input apc_byte_t d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         error_cnt++;
         print_verdict();
      end
      else
      begin
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask : xfer

   task automatic rd_chk(input logic [7:0] a, input apc_byte_t x);
      xfer(1'b0, a, 8'h00);
      `CHK(q, {24'h00_0000, x})
   endtask : rd_chk

   // Core event pulses, one cycle wide
   task automatic evt(input apc_chan_t s, input apc_chan_t a, input apc_chan_t r);
      ccf_set <= s;
      result_access <= a;
      result_read <= r;
      @(posedge pclk);
      ccf_set <= 8'h00;
      result_access <= 8'h00;
      result_read <= 8'h00;
      @(posedge pclk);
   endtask : evt

   // ==========================================================
   // Main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, special_mode_pin, trigger_pin} = '0;
      {wait_mode, sequence_complete_flag, paddr, pwdata} = '0;
      {ccf_set, result_access, result_read, error_cnt, n_checks} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reserved registers stay inert in normal mode
      rd_chk(8'h08, 8'h00);
      xfer(1'b1, 8'h00, 8'h5A);
      xfer(1'b1, 8'h04, 8'hA5);
      rd_chk(8'h00, 8'h00);
      rd_chk(8'h04, 8'h00);
      `CHK(test_control_a, 8'h00)
      special_mode_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      xfer(1'b1, 8'h00, 8'h5A);
      xfer(1'b1, 8'h04, 8'hA5);
      repeat (2) @(posedge pclk);
      `CHK(test_control_a, 8'h5A)
      `CHK(test_control_b, 8'hA5)
      rd_chk(8'h04, 8'hA5);
      special_mode_pin <= 1'b0;
      repeat (5) @(posedge pclk);
      `CHK(test_control_a, 8'h00)
      `CHK(test_control_b, 8'h00)
      rd_chk(8'h04, 8'h00);
      // Flag bit ignores writes; power and wait behaviour
      xfer(1'b1, 8'h08, 8'hFF);
      rd_chk(8'h08, 8'hFE);
      `CHK(converter_power, 1'b1)
      wait_mode <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK(converter_power, 1'b0)
      `CHK(conversion_halt, 1'b1)
      wait_mode <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK(converter_power, 1'b1)
      xfer(1'b1, 8'h08, 8'h82);
      wait_mode <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK(converter_power, 1'b1)
      wait_mode <= 1'b0;
      // Sequence complete flag and request, enabled then disabled
      sequence_complete_flag <= 1'b1;
      repeat (2) @(posedge pclk);
      rd_chk(8'h08, 8'h83);
      `CHK(sequence_irq, 1'b1)
      xfer(1'b1, 8'h08, 8'h80);
      rd_chk(8'h08, 8'h80);
      `CHK(sequence_irq, 1'b0)
      sequence_complete_flag <= 1'b0;
      xfer(1'b1, 8'h08, 8'h00);
      repeat (2) @(posedge pclk);
      `CHK(converter_power, 1'b0)
      // Every trigger sensitivity, then unarmed and unpowered cases
      for (int m = 0; m < 6; m++)
      begin
         trigger_pin <= (m < 4) ? ~m[0] : 1'b0;
         repeat (4) @(posedge pclk);
         xfer(1'b1, 8'h08, tcfg[m]); // no channel 7 result is read
         repeat (4) @(posedge pclk);
         trigger_pin <= ~trigger_pin;
         cnt = 0;
         repeat (12)
         begin
            @(posedge pclk);
            cnt += (trigger_start === 1'b1);
         end
         if (m >= 4) `CHK(cnt, 0)
         else if (m < 2) `CHK(cnt, 1)
         else `CHK(trigger_start, 1'b1)
      end
      // Interrupt status, mask and write-one-to-clear
      rd_chk(8'h0C, 8'h07);
      `CHK(irq, 1'b0)
      xfer(1'b1, 8'h10, 8'h02);
      rd_chk(8'h10, 8'h02);
      `CHK(irq, 1'b1)
      xfer(1'b1, 8'h0C, 8'h07);
      repeat (2) @(posedge pclk);
      rd_chk(8'h0C, 8'h00);
      `CHK(irq, 1'b0)
      xfer(1'b0, 8'h18, 8'h00);
      `CHK(e, 1'b1)
      // Fast clear, then normal two-step clear
      xfer(1'b1, 8'h08, 8'hC0);
      repeat (4) @(posedge pclk); // recovery after power-up
      evt(8'h01, 8'h00, 8'h00);
      rd_chk(8'h14, 8'h01);
      evt(8'h00, 8'h01, 8'h00);
      rd_chk(8'h14, 8'h00);
      xfer(1'b1, 8'h08, 8'h80);
      evt(8'h02, 8'h00, 8'h00);
      evt(8'h00, 8'h00, 8'h02);
      rd_chk(8'h14, 8'h02);
      `CHK(conversion_complete_flag, 8'h02)
      evt(8'h00, 8'h00, 8'h02);
      rd_chk(8'h14, 8'h00);
      print_verdict();
   end
endmodule : adc_power_trigger_irq_control_tb_top

`default_nettype wire
